//--- pkg/cdc_consts.vh
`ifndef CDC_CONSTS_VH
`define CDC_CONSTS_VH

// Register word indices; byte address is four times the index
`define CDC_REG_FETCH 2'h0
`define CDC_REG_CFG 2'h1
`define CDC_REG_STAT 2'h2
`define CDC_REG_CUR 2'h3
`define CDC_IDX_PRIO 5'h10
`define CDC_IDX_STATIC 5'h11

// Channel configuration bits
`define CDC_CFG_PER_DESC 0
`define CDC_CFG_WBACK 1
`define CDC_CFG_PULSE 2
`define CDC_CFG_RST 3'h4

// Status bits
`define CDC_ST_BUSY 0
`define CDC_ST_PEND 1
`define CDC_ST_DONE 2
`define CDC_ST_STALL 3

// Priority register: four 2-bit slots, round-robin enable
`define CDC_PRIO_RR 8
`define CDC_PRIO_RST 32'h0000_00E4
`define CDC_STATIC_RST 32'h0000_0000

// Descriptor header fields
`define CDC_HDR_DONE 0
`define CDC_HDR_DIR_LO 8
`define CDC_HDR_MODE_LO 20
`define CDC_HDR_TYPE_LO 28

// Descriptor geometry in 64-bit words
`define CDC_DESC_WORDS 4'h9
`define CDC_PAIRS 3'h7
`define CDC_NEXT_WORD 4'h8
`define CDC_WORD_BYTES 32'h0000_0008

`endif

//--- core/cdc_desc_mem.v
`timescale 1ns/100ps
// Descriptor buffers for all channels, registered read port
module cdc_desc_mem #(
	parameter W = 64,
	parameter AW = 6
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	// No reset on the array; contents are always written before use
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

//--- core/cdc_top.v
`timescale 1ns/100ps
`include "cdc_consts.vh"
module cdc_top #(
	parameter NCH = 4,
	parameter NEU = 4,
	parameter [4*NEU-1:0] EU_TYPES = 16'h3210
) (
	input wire MCLK,
	input wire SYS_RST,
	input wire [4:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	output reg M_READ,
	output reg M_WRITE,
	output reg [31:0] M_ADDR,
	output reg [63:0] M_WDATA,
	input wire [63:0] M_RDATA,
	input wire M_WAITREQUEST,
	output reg [NEU-1:0] EU_SEL,
	output reg [NEU-1:0] EU_RESET,
	output reg [7:0] EU_MODE,
	output reg [2:0] EU_SLOT,
	output reg EU_WVALID,
	output reg [63:0] EU_WDATA,
	input wire EU_WREADY,
	output reg EU_RREADY,
	input wire EU_RVALID,
	input wire [63:0] EU_RDATA,
	input wire [NEU-1:0] EU_BUSY,
	output reg [NCH-1:0] CH_DONE
);
	localparam [10:0] S_IDLE = 11'h001, S_FETCH = 11'h002, S_DECODE = 11'h004, S_ASSIGN = 11'h008;
	localparam [10:0] S_PSEL = 11'h010, S_PLOAD = 11'h020, S_XIN = 11'h040, S_XOUT = 11'h080;
	localparam [10:0] S_RELEASE = 11'h100, S_WBACK = 11'h200, S_NEXT = 11'h400;

	// Byte-enable merge of a 32-bit register
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0] be;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1) begin
				be_merge[b*8+:8] = be[b] ? din[b*8+:8] : old[b*8+:8];
			end
		end
	endfunction

	// Byte count to 64-bit word count, rounded up
	function [28:0] word_count;
		input [31:0] len;
		begin
			word_count = len[31:3] + {28'h000_0000, |len[2:0]};
		end
	endfunction

	reg [10:0] state_reg;
	reg [1:0] ch_reg;
	reg [1:0] last_ch_reg;
	reg [31:0] desc_ptr_reg;
	reg [63:0] hdr_reg;
	reg [31:0] next_ptr_reg;
	reg [3:0] word_reg;
	reg [2:0] pair_reg;
	reg [28:0] left_reg;
	reg [2:0] off_reg;
	reg prime_reg;
	reg [63:0] prev_reg;
	reg eu_dyn_reg;
	reg stall_reg;
	reg [31:0] prio_reg;
	reg [31:0] static_reg;
	reg [NCH-1:0] take_reg;
	reg [NCH-1:0] dset_reg;
	wire [32*NCH-1:0] fptr_all;
	wire [3*NCH-1:0] cfg_all;
	wire [NCH-1:0] pend_all;
	wire [NCH-1:0] done_all;
	wire avs_fire_wr = AVS_WRITE && !AVS_WAITREQUEST;
	wire [63:0] mem_rdata;
	wire mem_we = (state_reg == S_FETCH) && M_READ && !M_WAITREQUEST;
	wire [5:0] mem_raddr = {ch_reg, 1'b0, pair_reg + 3'h1};
	wire [2:0] cfg_cur = cfg_all[ch_reg*3+:3];

	cdc_desc_mem #(.W(64), .AW(6)) u_mem (
		.clk(MCLK),
		.we(mem_we),
		.waddr({ch_reg, word_reg}),
		.wdata(M_RDATA),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Per-channel registers; chain state is held once, in the shared channel engine
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			reg [31:0] fptr_reg;
			reg [2:0] cfg_reg;
			reg pend_reg;
			reg done_reg;
			wire hit = avs_fire_wr && !AVS_ADDRESS[4] && (AVS_ADDRESS[3:2] == g);
			wire set_pend = hit && (AVS_ADDRESS[1:0] == `CDC_REG_FETCH);
			wire clr_done = hit && (AVS_ADDRESS[1:0] == `CDC_REG_STAT) && AVS_BYTEENABLE[0]
				&& AVS_WRITEDATA[`CDC_ST_DONE];
			always @(posedge MCLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					fptr_reg <= 32'h0000_0000;
					cfg_reg <= `CDC_CFG_RST;
					pend_reg <= 1'b0;
					done_reg <= 1'b0;
				end else begin
					if (set_pend) begin
						fptr_reg <= be_merge(fptr_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
					end
					if (hit && (AVS_ADDRESS[1:0] == `CDC_REG_CFG) && AVS_BYTEENABLE[0]) begin
						cfg_reg <= AVS_WRITEDATA[2:0];
					end
					// A new pointer write wins over the engine taking the old one
					pend_reg <= (pend_reg && !take_reg[g]) || set_pend;
					done_reg <= (done_reg && !clr_done) || dset_reg[g];
				end
			end
			assign fptr_all[g*32+:32] = fptr_reg;
			assign cfg_all[g*3+:3] = cfg_reg;
			assign pend_all[g] = pend_reg;
			assign done_all[g] = done_reg;
		end
	endgenerate

	// Channel pick: fixed order from slots or round-robin after last grant
	reg grant_ok;
	reg [1:0] grant_ch;
	reg [1:0] cand;
	integer k;
	always @* begin
		grant_ok = 1'b0;
		grant_ch = 2'h0;
		cand = 2'h0;
		for (k = 3; k >= 0; k = k - 1) begin
			if (prio_reg[`CDC_PRIO_RR]) begin
				cand = last_ch_reg + k[1:0] + 2'h1;
			end else begin
				cand = prio_reg[k*2+:2];
			end
			if (pend_all[cand]) begin
				grant_ok = 1'b1;
				grant_ch = cand;
			end
		end
	end

	// Unit pick: static owner first, else any free unassigned unit of the type
	reg eu_ok;
	reg eu_dyn;
	reg [NEU-1:0] eu_pick;
	integer e;
	always @* begin
		eu_ok = 1'b0;
		eu_dyn = 1'b0;
		eu_pick = {NEU{1'b0}};
		for (e = NEU - 1; e >= 0; e = e - 1) begin
			if (EU_TYPES[e*4+:4] == hdr_reg[`CDC_HDR_TYPE_LO+:4]) begin
				if (static_reg[e*4+2] && (static_reg[e*4+:2] == ch_reg)) begin
					eu_ok = 1'b1;
					eu_dyn = 1'b0;
					eu_pick = {NEU{1'b0}};
					eu_pick[e] = 1'b1;
				end else if (!static_reg[e*4+2] && !EU_BUSY[e] && (eu_dyn || !eu_ok)) begin
					eu_ok = 1'b1;
					eu_dyn = 1'b1;
					eu_pick = {NEU{1'b0}};
					eu_pick[e] = 1'b1;
				end
			end
		end
	end

	// Register read mux
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0000_0000;
		if (!AVS_ADDRESS[4]) begin
			case (AVS_ADDRESS[1:0])
				`CDC_REG_FETCH: rd_val = fptr_all[AVS_ADDRESS[3:2]*32+:32];
				`CDC_REG_CFG: rd_val = {29'h0000_0000, cfg_all[AVS_ADDRESS[3:2]*3+:3]};
				`CDC_REG_STAT: rd_val = {28'h000_0000,
					stall_reg && (ch_reg == AVS_ADDRESS[3:2]) && (state_reg != S_IDLE),
					done_all[AVS_ADDRESS[3:2]], pend_all[AVS_ADDRESS[3:2]],
					(ch_reg == AVS_ADDRESS[3:2]) && (state_reg != S_IDLE)};
				default: rd_val = (ch_reg == AVS_ADDRESS[3:2]) ? desc_ptr_reg : 32'h0000_0000;
			endcase
		end else if (AVS_ADDRESS == `CDC_IDX_PRIO) begin
			rd_val = prio_reg;
		end else if (AVS_ADDRESS == `CDC_IDX_STATIC) begin
			rd_val = static_reg;
		end
	end

	// Slave handshake: one wait cycle, then a single completing cycle
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
			prio_reg <= `CDC_PRIO_RST;
			static_reg <= `CDC_STATIC_RST;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
			if (AVS_READ && AVS_WAITREQUEST) begin
				AVS_READDATA <= rd_val;
			end
			if (avs_fire_wr && (AVS_ADDRESS == `CDC_IDX_PRIO)) begin
				prio_reg <= be_merge(prio_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
			end
			if (avs_fire_wr && (AVS_ADDRESS == `CDC_IDX_STATIC)) begin
				static_reg <= be_merge(static_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
			end
		end
	end

	wire m_done = (M_READ || M_WRITE) && !M_WAITREQUEST;
	wire last_desc = (next_ptr_reg == 32'h0000_0000);
	wire notify = cfg_cur[`CDC_CFG_PER_DESC] || last_desc;
	wire [127:0] joined = {M_RDATA, prev_reg} >> {off_reg, 3'h0};

	// Channel engine; one channel owns the master port at a time
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg <= S_IDLE;
			ch_reg <= 2'h0;
			last_ch_reg <= 2'h3;
			desc_ptr_reg <= 32'h0000_0000;
			hdr_reg <= 64'h0000_0000_0000_0000;
			next_ptr_reg <= 32'h0000_0000;
			word_reg <= 4'h0;
			pair_reg <= 3'h0;
			left_reg <= 29'h0000_0000;
			off_reg <= 3'h0;
			prime_reg <= 1'b0;
			prev_reg <= 64'h0000_0000_0000_0000;
			eu_dyn_reg <= 1'b0;
			stall_reg <= 1'b0;
			take_reg <= {NCH{1'b0}};
			dset_reg <= {NCH{1'b0}};
			M_READ <= 1'b0;
			M_WRITE <= 1'b0;
			M_ADDR <= 32'h0000_0000;
			M_WDATA <= 64'h0000_0000_0000_0000;
			EU_SEL <= {NEU{1'b0}};
			EU_RESET <= {NEU{1'b0}};
			EU_MODE <= 8'h00;
			EU_SLOT <= 3'h0;
			EU_WVALID <= 1'b0;
			EU_WDATA <= 64'h0000_0000_0000_0000;
			EU_RREADY <= 1'b0;
			CH_DONE <= {NCH{1'b0}};
		end else begin
			take_reg <= {NCH{1'b0}};
			dset_reg <= {NCH{1'b0}};
			EU_RESET <= {NEU{1'b0}};
			CH_DONE <= {NCH{1'b0}};
			case (state_reg)
				S_IDLE: begin
					if (grant_ok && !take_reg[grant_ch]) begin
						ch_reg <= grant_ch;
						last_ch_reg <= grant_ch;
						take_reg[grant_ch] <= 1'b1;
						desc_ptr_reg <= fptr_all[grant_ch*32+:32];
						word_reg <= 4'h0;
						state_reg <= S_FETCH;
					end
				end
				S_FETCH: begin
					// Descriptor read as consecutive 64-bit words
					M_READ <= !m_done;
					M_ADDR <= desc_ptr_reg + {25'h000_0000, word_reg, 3'h0};
					if (m_done) begin
						if (word_reg == 4'h0) begin
							hdr_reg <= M_RDATA;
						end
						if (word_reg == `CDC_NEXT_WORD) begin
							next_ptr_reg <= M_RDATA[31:0];
							state_reg <= S_DECODE;
						end
						word_reg <= word_reg + 4'h1;
					end
				end
				S_DECODE: begin
					EU_MODE <= hdr_reg[`CDC_HDR_MODE_LO+:8];
					pair_reg <= 3'h0;
					state_reg <= S_ASSIGN;
				end
				S_ASSIGN: begin
					// No data is fetched until a unit is held
					stall_reg <= !eu_ok;
					if (eu_ok) begin
						EU_SEL <= eu_pick;
						eu_dyn_reg <= eu_dyn;
						state_reg <= S_PSEL;
					end
				end
				S_PSEL: begin
					// Memory read of the pair is in flight this cycle
					state_reg <= (pair_reg == `CDC_PAIRS) ? S_RELEASE : S_PLOAD;
				end
				S_PLOAD: begin
					EU_SLOT <= pair_reg;
					left_reg <= word_count(mem_rdata[31:0]);
					off_reg <= mem_rdata[34:32];
					prime_reg <= |mem_rdata[34:32];
					M_ADDR <= {mem_rdata[63:35], 3'h0};
					if (mem_rdata[31:0] == 32'h0000_0000) begin
						pair_reg <= pair_reg + 3'h1;
						state_reg <= S_PSEL;
					end else if (hdr_reg[`CDC_HDR_DIR_LO + pair_reg]) begin
						state_reg <= S_XOUT;
					end else begin
						state_reg <= S_XIN;
					end
				end
				S_XIN: begin
					// Byte-aligned source: at a nonzero offset each unit word joins two bus words
					if (EU_WVALID) begin
						EU_WVALID <= !EU_WREADY;
					end else if (m_done) begin
						M_READ <= 1'b0;
						M_ADDR <= M_ADDR + `CDC_WORD_BYTES;
						prev_reg <= M_RDATA;
						prime_reg <= 1'b0;
						if (!prime_reg) begin
							EU_WDATA <= (off_reg == 3'h0) ? M_RDATA : joined[63:0];
							EU_WVALID <= 1'b1;
							left_reg <= left_reg - 29'h0000_0001;
						end
					end else if (left_reg != 29'h0000_0000) begin
						M_READ <= 1'b1;
					end else begin
						pair_reg <= pair_reg + 3'h1;
						state_reg <= S_PSEL;
					end
				end
				S_XOUT: begin
					// Unit output buffer drained word by word to memory
					if (m_done) begin
						M_WRITE <= 1'b0;
						M_ADDR <= M_ADDR + `CDC_WORD_BYTES;
						left_reg <= left_reg - 29'h0000_0001;
					end else if (M_WRITE) begin
						M_WRITE <= 1'b1;
					end else if (EU_RREADY && EU_RVALID) begin
						EU_RREADY <= 1'b0;
						M_WDATA <= EU_RDATA;
						M_WRITE <= 1'b1;
					end else if (left_reg != 29'h0000_0000) begin
						EU_RREADY <= 1'b1;
					end else begin
						pair_reg <= pair_reg + 3'h1;
						state_reg <= S_PSEL;
					end
				end
				S_RELEASE: begin
					// Only dynamically held units are reset on release
					if (eu_dyn_reg) begin
						EU_RESET <= EU_SEL;
					end
					EU_SEL <= {NEU{1'b0}};
					if (notify && cfg_cur[`CDC_CFG_PULSE]) begin
						CH_DONE[ch_reg] <= 1'b1;
						dset_reg[ch_reg] <= 1'b1;
					end
					state_reg <= (notify && cfg_cur[`CDC_CFG_WBACK]) ? S_WBACK : S_NEXT;
				end
				S_WBACK: begin
					M_WRITE <= !m_done;
					M_ADDR <= desc_ptr_reg;
					M_WDATA <= hdr_reg | 64'h0000_0000_0000_0001;
					if (m_done) begin
						state_reg <= S_NEXT;
					end
				end
				S_NEXT: begin
					if (!last_desc) begin
						desc_ptr_reg <= next_ptr_reg;
						word_reg <= 4'h0;
						state_reg <= S_FETCH;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

//--- sim/cdc_checker.sv
`timescale 1ns/100ps
module cdc_checker #(
	parameter NCH = 4,
	parameter NEU = 4
) (
	input wire MCLK,
	input wire SYS_RST,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire AVS_WAITREQUEST,
	input wire M_READ,
	input wire M_WRITE,
	input wire [31:0] M_ADDR,
	input wire [63:0] M_WDATA,
	input wire M_WAITREQUEST,
	input wire [NEU-1:0] EU_SEL,
	input wire [2:0] EU_SLOT,
	input wire EU_WVALID,
	input wire [63:0] EU_WDATA,
	input wire EU_WREADY,
	input wire [NCH-1:0] CH_DONE
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	// Steps of a master access: waiting, then answered
	sequence s_rd_wait;
		M_READ && M_WAITREQUEST;
	endsequence
	sequence s_wr_wait;
		M_WRITE && M_WAITREQUEST;
	endsequence
	sequence s_rd_done;
		M_READ && !M_WAITREQUEST;
	endsequence
	a_slave_answer: assert property ($rose(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("slave answer late");
	a_slave_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_read_held: assert property (s_rd_wait |=> M_READ && $stable(M_ADDR))
		else $error("read dropped early");
	a_write_held: assert property (s_wr_wait |=> M_WRITE && $stable(M_ADDR) && $stable(M_WDATA))
		else $error("write dropped early");
	a_read_release: assert property (s_rd_done |=> !M_READ)
		else $error("read not released");
	a_rw_apart: assert property (!(M_READ && M_WRITE))
		else $error("read and write together");
	a_word_aligned: assert property (M_READ || M_WRITE |-> M_ADDR[2:0] == 3'h0)
		else $error("master address unaligned");
	a_unit_hold: assert property (EU_WVALID && !EU_WREADY |=> EU_WVALID && $stable(EU_WDATA))
		else $error("unit data dropped");
	a_unit_select: assert property (EU_WVALID |-> $onehot(EU_SEL) && EU_SLOT < 3'h7)
		else $error("bad unit select");
	a_done_pulse: assert property (|CH_DONE |=> CH_DONE == '0)
		else $error("done not a pulse");
endmodule

bind cdc_top cdc_checker #(.NCH(NCH), .NEU(NEU)) u_chk (.*);

//--- sim/cdc_mem_model.sv
`timescale 1ns/100ps
module cdc_mem_model (
	input wire clk,
	input wire rst,
	input wire [3:0] lat,
	input wire slow,
	input wire m_read,
	input wire m_write,
	input wire [31:0] m_addr,
	input wire [63:0] m_wdata,
	output logic [63:0] m_rdata,
	output logic m_waitrequest,
	input wire eu_wvalid,
	input wire [63:0] eu_wdata,
	output logic eu_wready,
	input wire eu_rready,
	output logic eu_rvalid,
	output logic [63:0] eu_rdata
);
	logic [63:0] mem [256];
	logic [63:0] fifo [$];
	logic [3:0] cnt_reg;
	// Memory answers after lat+1 wait cycles; read data is garbage outside the answer cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			m_waitrequest <= 1'b1;
			cnt_reg <= 4'h0;
			m_rdata <= 64'h0;
		end else begin
			m_waitrequest <= 1'b1;
			m_rdata <= ~m_rdata;
			if (!m_waitrequest) begin
				cnt_reg <= 4'h0;
				if (m_write)
					mem[m_addr[10:3]] <= m_wdata;
			end else if (m_read || m_write) begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == lat) begin
					m_waitrequest <= 1'b0;
					if (m_read)
						m_rdata <= mem[m_addr[10:3]];
				end
			end
		end
	end
	// Unit echoes its input in order, so output regions mirror input bytes
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fifo.delete();
			eu_wready <= 1'b0;
			eu_rvalid <= 1'b0;
			eu_rdata <= 64'h0;
		end else begin
			eu_wready <= slow ? ~eu_wready : 1'b1;
			if (eu_rready && eu_rvalid)
				void'(fifo.pop_front());
			if (eu_wvalid && eu_wready)
				fifo.push_back(eu_wdata);
			eu_rvalid <= fifo.size() > 0;
			eu_rdata <= fifo.size() > 0 ? fifo[0] : ~eu_rdata;
		end
	end
endmodule

//--- sim/cdc_top_test.sv
`timescale 1ns/100ps
`include "cdc_consts.vh"
module cdc_top_test;
	localparam [63:0] HDR = 64'h1234_5678_15A0_0800;
	logic MCLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [4:0] AVS_ADDRESS = 5'h0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [3:0] EU_BUSY = 4'h0;
	logic [3:0] lat = 4'h0;
	logic eu_slow = 1'b0;
	logic [31:0] AVS_READDATA, M_ADDR, q;
	logic AVS_WAITREQUEST, M_READ, M_WRITE, M_WAITREQUEST, EU_WVALID, EU_WREADY, EU_RREADY, EU_RVALID;
	logic [63:0] M_WDATA, M_RDATA, EU_WDATA, EU_RDATA;
	logic [3:0] EU_SEL, EU_RESET, CH_DONE, sel_seen;
	logic [7:0] EU_MODE, mode_seen;
	logic [2:0] EU_SLOT;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int wr_seen = 0;
	int done_n [4] = '{0, 0, 0, 0};
	int unit_resets = 0;
	logic [7:0] order_seen = 8'h00;

	cdc_top dut (.*);
	cdc_mem_model m (.clk(MCLK), .rst(SYS_RST), .lat(lat), .slow(eu_slow), .m_read(M_READ), .m_write(M_WRITE),
		.m_addr(M_ADDR), .m_wdata(M_WDATA), .m_rdata(M_RDATA), .m_waitrequest(M_WAITREQUEST),
		.eu_wvalid(EU_WVALID), .eu_wdata(EU_WDATA), .eu_wready(EU_WREADY), .eu_rready(EU_RREADY),
		.eu_rvalid(EU_RVALID), .eu_rdata(EU_RDATA));

	always #2 MCLK = ~MCLK;

	// Done pulses, unit traffic and the hang limit
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		// Channel order of done pulses; only one engine, so one pulse per cycle
		for (int i = 0; i < 4; i++) begin
			done_n[i] <= done_n[i] + CH_DONE[i];
			if (CH_DONE[i])
				order_seen <= {order_seen[5:0], 2'(i)};
		end
		unit_resets <= unit_resets + (|EU_RESET);
		if (EU_WVALID && EU_WREADY) begin
			wr_seen <= wr_seen + 1;
			mode_seen <= EU_MODE;
			sel_seen <= EU_SEL;
		end
		if (cyc == 30000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input [63:0] got, input [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low
	// Only the bench timeout ends a wait that never comes
	task automatic av(input [4:0] a, input w, input [31:0] d);
		@(posedge MCLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		do begin
			@(posedge MCLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	function automatic [7:0] byt(input [31:0] a);
		byt = m.mem[a[10:3]][8*a[2:0] +: 8];
	endfunction

	// Output words must hold the input bytes from the source pointer on
	task automatic cmp_out(input [31:0] s, input [31:0] d);
		logic [63:0] e;
		for (int w = 0; w < 2; w++) begin
			for (int b = 0; b < 8; b++)
				e[8*b +: 8] = byt(s + 8*w + b);
			chk(m.mem[d[10:3] + w], e);
		end
	endtask

	// Key pair has a pointer but zero length, so it must be skipped
	task automatic desc(input [31:0] a, input [31:0] s, input [31:0] d, input [31:0] nx);
		for (int i = 0; i < 9; i++)
			m.mem[a[10:3] + i] = 64'h0;
		m.mem[a[10:3]] = HDR;
		m.mem[a[10:3] + 2] = {32'h0000_07F8, 32'h0};
		m.mem[a[10:3] + 3] = {s, 32'h0000_0010};
		m.mem[a[10:3] + 4] = {d, 32'h0000_0010};
		m.mem[a[10:3] + 8] = {32'h0, nx};
		m.mem[d[10:3]] = 64'h0;
		m.mem[d[10:3] + 1] = 64'h0;
	endtask

	// Waits past the expected count so a surplus pulse is seen too
	task automatic wait_done(input int ch, input int n);
		int t;
		t = 0;
		while (done_n[ch] < n && t < 6000) begin
			@(posedge MCLK);
			t++;
		end
		repeat (200) @(posedge MCLK);
		chk(done_n[ch], n);
	endtask

	task automatic t_regs();
		av(`CDC_REG_CFG, 1'b0, 32'h0);
		chk(q, 32'h0000_0004);
		av(`CDC_IDX_PRIO, 1'b0, 32'h0);
		chk(q, `CDC_PRIO_RST);
		av(`CDC_IDX_STATIC, 1'b0, 32'h0);
		chk(q, `CDC_STATIC_RST);
		av(5'h12, 1'b1, 32'hFFFF_FFFF);
		av(5'h12, 1'b0, 32'h0);
		chk(q, 32'h0);
	endtask

	task automatic t_single();
		desc(32'h0000_0100, 32'h0000_0200, 32'h0000_0300, 32'h0);
		av(`CDC_REG_FETCH, 1'b1, 32'h0000_0100);
		wait_done(0, 1);
		cmp_out(32'h0000_0200, 32'h0000_0300);
		chk(mode_seen, HDR[27:20]);
		chk(sel_seen, 4'b0010);
		chk(unit_resets, 1);
		// Current pointer keeps the last descriptor address once idle
		av(`CDC_REG_CUR, 1'b0, 32'h0);
		chk(q, 32'h0000_0100);
		av(`CDC_REG_STAT, 1'b0, 32'h0);
		chk(q[3:0], 4'b0100);
	endtask

	// Two-descriptor chain, slow memory and unit, unaligned first source
	task automatic t_chain(input int ch, input [2:0] cfg, input int n);
		int b;
		b = done_n[ch];
		lat <= 4'h3;
		eu_slow <= 1'b1;
		desc(32'h0000_0100, 32'h0000_0203, 32'h0000_0300, 32'h0000_0180);
		desc(32'h0000_0180, 32'h0000_0240, 32'h0000_0340, 32'h0);
		av(5'(ch*4 + `CDC_REG_CFG), 1'b1, {29'h0, cfg});
		av(5'(ch*4 + `CDC_REG_FETCH), 1'b1, 32'h0000_0100);
		wait_done(ch, b + n);
		cmp_out(32'h0000_0203, 32'h0000_0300);
		cmp_out(32'h0000_0240, 32'h0000_0340);
		chk(m.mem[6'h30], cfg[1] ? HDR | 64'h1 : HDR);
	endtask

	// Channels 0 and 3 queue behind a stalled channel 2; round-robin serves 3 first
	task automatic t_stall();
		int b;
		int w;
		int b0;
		int b3;
		b = done_n[2];
		w = wr_seen;
		EU_BUSY <= 4'b0010;
		desc(32'h0000_0100, 32'h0000_0200, 32'h0000_0300, 32'h0);
		av(5'h8, 1'b1, 32'h0000_0100);
		repeat (300) @(posedge MCLK);
		av(5'hA, 1'b0, 32'h0);
		chk(q[3], 1'b1);
		chk(wr_seen, w);
		av(`CDC_IDX_PRIO, 1'b1, 32'h0000_01E4);
		av(`CDC_IDX_PRIO, 1'b0, 32'h0);
		chk(q, 32'h0000_01E4);
		b0 = done_n[0];
		b3 = done_n[3];
		av(`CDC_REG_FETCH, 1'b1, 32'h0000_0100);
		av(5'hC, 1'b1, 32'h0000_0100);
		EU_BUSY <= 4'b0000;
		wait_done(2, b + 1);
		wait_done(3, b3 + 1);
		wait_done(0, b0 + 1);
		chk(order_seen[5:0], 6'b10_11_00);
		cmp_out(32'h0000_0200, 32'h0000_0300);
	endtask

	// Statically held unit: busy input ignored, no reset on release
	task automatic t_static();
		int b;
		int r;
		b = done_n[0];
		r = unit_resets;
		EU_BUSY <= 4'b0010;
		av(`CDC_IDX_STATIC, 1'b1, 32'h0000_0040);
		desc(32'h0000_0100, 32'h0000_0208, 32'h0000_0300, 32'h0);
		av(`CDC_REG_FETCH, 1'b1, 32'h0000_0100);
		wait_done(0, b + 1);
		chk(unit_resets, r);
		chk(sel_seen, 4'b0010);
		cmp_out(32'h0000_0208, 32'h0000_0300);
		EU_BUSY <= 4'b0000;
	endtask

	initial begin
		for (int i = 0; i < 256; i++)
			m.mem[i] = 64'h0123_4567_89AB_CDEF ^ {8{i[7:0]}};
		repeat (5) @(posedge MCLK);
		SYS_RST <= 1'b0;
		t_regs();
		t_single();
		t_chain(1, 3'b110, 1);
		t_chain(3, 3'b101, 2);
		t_stall();
		t_static();
		end_of_test();
	end
endmodule
